// *** design/hdao_regs.svh ***
// Purpose: constants for the haptic drive advanced options block
// Assumes: 20 MHz sys_clk
// Notes: one define per offset, field, reset value and timing count
`ifndef HDAO_REGS_SVH
`define HDAO_REGS_SVH
`define HDAO_CLK_HZ 20000000
`define HDAO_UV_SEL_RESET 2'h1
`define HDAO_UV_BASE_MV 2700
`define HDAO_UV_STEP_MV 100
`define HDAO_VDD_HI_SHIFT 7
`define HDAO_VDD_LSB_UV_X10000 1831
`define HDAO_MARGIN_STEP_UV 187500
`define HDAO_MARGIN_STEP_CODES 1024
`define HDAO_FAULT_TIME_US 50000
`define HDAO_FAULT_CYCLES ((`HDAO_FAULT_TIME_US * 20) - 0)
`define HDAO_SEQ_FRAMES_MAX 4'hf
`endif

// *** design/hdao_pkg.sv ***
// Purpose: types shared by the haptic drive advanced options block
// Assumes: nothing
// Notes: states gray coded in the order inactive, drive, brake, fault
package hdao_pkg;
    typedef enum logic [1:0] {
        HDAO_INACTIVE = 2'b00,
        HDAO_DRIVE = 2'b01,
        HDAO_BRAKE = 2'b11,
        HDAO_FAULT = 2'b10
    } hdao_state_type;
endpackage

// *** design/hdao_sync.sv ***
// Purpose: three-flop pin synchroniser with agreement check
// Assumes: async input
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module hdao_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic pin_in,
    output logic pin_out
);
    logic s1_reg, s2_reg, s3_reg, out_reg;
    logic s1_next, s2_next, s3_next, out_next;
    always_comb begin
        s1_next = pin_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
        // change counts only once two later stages agree
        out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            out_reg <= 1'b0;
        end else if (clk_en) begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            out_reg <= out_next;
        end
    end
    assign pin_out = out_reg;
endmodule // hdao_sync

// *** design/hdao_core.sv ***
// Purpose: drive control options: fault clearing, polarity report, supply limit,
//          motion fault check, tracking pause and frame sequencing
// Assumes: analog measurements arrive as sys_clk-domain codes; short pin is async
// Notes: analog trims pass through as combinational outputs
`timescale 1ns/1ps
`include "hdao_regs.svh"
module hdao_core #(
    parameter int unsigned FAULT_CYCLES = `HDAO_FAULT_CYCLES,
    parameter int unsigned AMP_W = 12
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic standalone_mode,
    input wire logic direct_override_mode,
    input wire logic [AMP_W-1:0] direct_amplitude_value,
    input wire logic [1:0] filter_cap_trim,
    input wire logic [1:0] filter_res_trim,
    input wire logic filter_low_bandwidth,
    input wire logic [1:0] undervoltage_threshold_sel,
    input wire logic current_range_double,
    input wire logic [4:0] current_limit_code,
    input wire logic [7:0] motion_fault_threshold,
    input wire logic impedance_offset_en,
    input wire logic tracking_pause_on_brake,
    input wire logic [3:0] vdd_margin,
    input wire logic [3:0] sequence_frames,
    input wire logic play_req,
    input wire logic stop_req,
    input wire logic fault_clear,
    input wire logic short_pin,
    input wire logic half_period_start,
    input wire logic frame_done,
    input wire logic [7:0] motion_level,
    input wire logic [13:0] vdd_sample,
    input wire logic [9:0] impedance_raw,
    input wire logic [AMP_W-1:0] impedance_offset,
    output logic drive_en,
    output logic current_loop_en,
    output logic tracking_update_en,
    output logic [AMP_W-1:0] drive_amplitude,
    output logic [5:0] current_limit_ma_x8,
    output logic polarity_status,
    output logic [6:0] vdd_hi,
    output logic [6:0] vdd_lo,
    output logic [9:0] impedance_readback,
    output logic impedance_lsb_half,
    output logic [3:0] frame_index,
    output logic short_fault,
    output logic motion_fault,
    output logic fault_irq,
    output logic [11:0] uv_threshold_mv,
    output logic [4:0] analog_filter_trim
);
    logic short_sync;
    hdao_sync u_short_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pin_in(short_pin),
        .pin_out(short_sync)
    );

    function automatic logic [AMP_W-1:0] cap_amp(input logic [AMP_W-1:0] a,
                                                 input logic [AMP_W-1:0] lim);
        cap_amp = (a > lim) ? lim : a;
    endfunction

    hdao_pkg::hdao_state_type state_reg, state_next;
    logic pol_reg, pol_next;
    logic short_reg, short_next, motion_reg, motion_next;
    logic [3:0] frame_reg, frame_next;
    logic [31:0] low_cnt_reg, low_cnt_next;
    logic [6:0] vhi_reg, vhi_next, vlo_reg, vlo_next;
    logic [9:0] imp_reg, imp_next;
    logic [AMP_W-1:0] amp_reg, amp_next;
    logic [AMP_W-1:0] vlimit;
    logic [AMP_W-1:0] amp_src;
    logic [AMP_W+3:0] margin_codes;
    logic playing;

    assign playing = (state_reg == hdao_pkg::HDAO_DRIVE) ||
                     (state_reg == hdao_pkg::HDAO_BRAKE);
    // headroom in supply codes, with 0 meaning none
    assign margin_codes = (AMP_W + 4)'(vdd_margin) * (AMP_W + 4)'(`HDAO_MARGIN_STEP_CODES);
    always_comb begin
        logic [AMP_W+3:0] vfull;
        vfull = (AMP_W + 4)'(vdd_sample);
        if (vfull > margin_codes)
            vlimit = AMP_W'((vfull - margin_codes) >> 2);
        else
            vlimit = '0;
    end
    assign amp_src = direct_override_mode ? direct_amplitude_value : {AMP_W{1'b1}};

    always_comb begin
        state_next = state_reg;
        pol_next = pol_reg;
        short_next = short_reg;
        motion_next = motion_reg;
        frame_next = frame_reg;
        low_cnt_next = low_cnt_reg;
        vhi_next = vhi_reg;
        vlo_next = vlo_reg;
        imp_next = imp_reg;
        amp_next = amp_reg;
        if (short_sync)
            short_next = 1'b1;
        else if (fault_clear)
            short_next = 1'b0;
        if (playing && half_period_start)
            pol_next = ~pol_reg;
        if (playing) begin
            vhi_next = vdd_sample[13:7];
            vlo_next = vdd_sample[6:0];
            amp_next = cap_amp(amp_src, vlimit);
            if (motion_fault_threshold != 8'h00 && motion_level < motion_fault_threshold) begin
                low_cnt_next = low_cnt_reg + 32'h1;
                if (low_cnt_reg >= FAULT_CYCLES - 1)
                    motion_next = 1'b1;
            end else begin
                low_cnt_next = '0;
            end
        end else begin
            amp_next = '0;
            low_cnt_next = '0;
            if (fault_clear && !short_sync)
                motion_next = 1'b0;
        end
        // offset is added to the raw impedance reading when enabled
        imp_next = impedance_offset_en ? 10'(impedance_raw + 10'(impedance_offset))
                                       : impedance_raw;
        unique case (state_reg)
            hdao_pkg::HDAO_INACTIVE: begin
                frame_next = '0;
                // standalone wipes faults here so the next request plays
                if (standalone_mode && !short_sync) begin
                    short_next = 1'b0;
                    motion_next = 1'b0;
                end
                if (play_req && !short_sync && (standalone_mode || !(short_reg || motion_reg)))
                    state_next = hdao_pkg::HDAO_DRIVE;
            end
            hdao_pkg::HDAO_DRIVE: begin
                if (short_sync || motion_next)
                    state_next = hdao_pkg::HDAO_FAULT;
                else if (stop_req)
                    state_next = hdao_pkg::HDAO_BRAKE;
                else if (frame_done) begin
                    if (frame_reg >= sequence_frames)
                        state_next = hdao_pkg::HDAO_BRAKE;
                    else
                        frame_next = frame_reg + 4'h1;
                end
            end
            hdao_pkg::HDAO_BRAKE: begin
                if (short_sync)
                    state_next = hdao_pkg::HDAO_FAULT;
                else if (half_period_start)
                    state_next = hdao_pkg::HDAO_INACTIVE;
            end
            hdao_pkg::HDAO_FAULT: begin
                state_next = hdao_pkg::HDAO_INACTIVE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= hdao_pkg::HDAO_INACTIVE;
            pol_reg <= 1'b0;
            short_reg <= 1'b0;
            motion_reg <= 1'b0;
            frame_reg <= 4'h0;
            low_cnt_reg <= 32'h0;
            vhi_reg <= 7'h00;
            vlo_reg <= 7'h00;
            imp_reg <= 10'h000;
            amp_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            pol_reg <= pol_next;
            short_reg <= short_next;
            motion_reg <= motion_next;
            frame_reg <= frame_next;
            low_cnt_reg <= low_cnt_next;
            vhi_reg <= vhi_next;
            vlo_reg <= vlo_next;
            imp_reg <= imp_next;
            amp_reg <= amp_next;
        end
    end

    // readbacks have no write path at all
    assign polarity_status = pol_reg;
    assign vdd_hi = vhi_reg;
    assign vdd_lo = vlo_reg;
    assign impedance_readback = imp_reg;
    assign impedance_lsb_half = current_range_double;
    assign drive_en = playing;
    assign current_loop_en = playing;
    assign tracking_update_en = (state_reg == hdao_pkg::HDAO_DRIVE) ||
                                (playing && !tracking_pause_on_brake);
    assign drive_amplitude = amp_reg;
    assign current_limit_ma_x8 = current_range_double ? {current_limit_code, 1'b0}
                                                      : {1'b0, current_limit_code};
    assign frame_index = frame_reg;
    assign short_fault = short_reg;
    assign motion_fault = motion_reg;
    assign fault_irq = short_reg | motion_reg;
    assign uv_threshold_mv = 12'(`HDAO_UV_BASE_MV) +
                             12'(undervoltage_threshold_sel) * 12'(`HDAO_UV_STEP_MV);
    assign analog_filter_trim = {filter_low_bandwidth, filter_res_trim, filter_cap_trim};

    short_stops_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && short_sync && state_reg == hdao_pkg::HDAO_DRIVE |=> !drive_en ##1 !drive_en)
        else $error("short did not stop drive");
    auto_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && standalone_mode && !short_sync && state_reg == hdao_pkg::HDAO_INACTIVE
        |=> !short_fault && !motion_fault)
        else $error("standalone faults not cleared");
    replay_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && standalone_mode && play_req && !short_sync &&
        state_reg == hdao_pkg::HDAO_INACTIVE |=> drive_en)
        else $error("standalone play refused");
    polarity_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && playing && half_period_start |=> polarity_status != $past(polarity_status))
        else $error("polarity did not toggle");
    uv_range_a: assert property (@(posedge sys_clk) disable iff (rst)
        uv_threshold_mv >= 12'ha8c && uv_threshold_mv <= 12'hbb8)
        else $error("uv threshold out of range");
    double_a: assert property (@(posedge sys_clk) disable iff (rst)
        current_range_double |-> current_limit_ma_x8 == {current_limit_code, 1'b0})
        else $error("double range not applied");
    cap_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && playing |=> drive_amplitude <= $past(vlimit))
        else $error("drive above supply limit");
    nocheck_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && motion_fault_threshold == 8'h00
        |=> low_cnt_reg == 32'h0 && !$rose(motion_fault))
        else $error("motion check with zero threshold");
    pause_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg == hdao_pkg::HDAO_BRAKE && tracking_pause_on_brake |-> !tracking_update_en)
        else $error("tracking not paused in brake");
    vdd_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && playing |=> {vdd_hi, vdd_lo} == $past(vdd_sample))
        else $error("supply report wrong");
endmodule // hdao_core

// *** dv/hdao_act_model.sv ***
// Purpose: actuator side of the core: half periods, frames, motion and short pin
// Assumes: pulses change on the falling edge of sys_clk
// Notes: motion stays low only while the bench commands a stuck actuator
`timescale 1ns/1ps
module hdao_act_model (
    input wire logic sys_clk,
    input wire logic drive_en,
    input wire logic stuck,
    input wire logic short_cmd,
    output logic half_period_start,
    output logic frame_done,
    output logic [7:0] motion_level,
    output logic short_pin
);
    int hp_cnt = 0;
    int fr_cnt = 0;
    // half periods follow the free swing, frames advance only while driven
    always @(negedge sys_clk) begin
        hp_cnt = (hp_cnt + 1) % 6;
        fr_cnt = drive_en ? (fr_cnt + 1) % 10 : 0;
        half_period_start <= (hp_cnt == 0);
        frame_done <= (fr_cnt == 9);
    end
    assign motion_level = stuck ? 8'h00 : 8'h80;
    assign short_pin = short_cmd;
endmodule // hdao_act_model

// *** dv/tb.sv ***
// Purpose: self-checking bench for the haptic drive options core
// Assumes: 20 MHz sys_clk, inputs change on the falling edge
// Notes: motion fault time shortened to 8 cycles
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0, rst = 1'b1, standalone_mode = 1'b0, direct_override_mode = 1'b0;
    logic [11:0] direct_amplitude_value = 12'h800;
    logic [1:0] undervoltage_threshold_sel = 2'h1;
    logic current_range_double = 1'b0, impedance_offset_en = 1'b0, tracking_pause_on_brake = 1'b0;
    logic [4:0] current_limit_code = 5'h13;
    logic [7:0] motion_fault_threshold = 8'h10;
    logic [3:0] vdd_margin = 4'h0, sequence_frames = 4'h2;
    logic play_req = 1'b0, stop_req = 1'b0, fault_clear = 1'b0, stuck = 1'b0, short_cmd = 1'b0;
    logic [13:0] vdd_sample = 14'h3fff;
    logic [9:0] impedance_raw = 10'h2c3;
    logic clk_en = 1'b1, filter_low_bandwidth = 1'b0; // actuator well below 1 mH
    logic [1:0] filter_cap_trim = 2'h3, filter_res_trim = 2'h2; // 10 ohm, 75 uH
    logic [11:0] impedance_offset = 12'h005;
    logic [4:0] analog_filter_trim;
    logic short_pin, half_period_start, frame_done, drive_en, current_loop_en;
    logic tracking_update_en, polarity_status, impedance_lsb_half, short_fault;
    logic motion_fault, fault_irq;
    logic [7:0] motion_level;
    logic [11:0] drive_amplitude, uv_threshold_mv;
    logic [5:0] current_limit_ma_x8;
    logic [6:0] vdd_hi, vdd_lo;
    logic [9:0] impedance_readback;
    logic [3:0] frame_index;
    int n_mismatch = 0;
    int compares = 0;
    always #25 sys_clk = ~sys_clk;
    hdao_core #(.FAULT_CYCLES(8), .AMP_W(12)) uut (.sys_clk, .rst, .clk_en,
        .standalone_mode, .direct_override_mode, .direct_amplitude_value,
        .filter_cap_trim, .filter_res_trim, .filter_low_bandwidth,
        .undervoltage_threshold_sel, .current_range_double, .current_limit_code,
        .motion_fault_threshold, .impedance_offset_en, .tracking_pause_on_brake, .vdd_margin,
        .sequence_frames, .play_req, .stop_req, .fault_clear, .short_pin, .half_period_start,
        .frame_done, .motion_level, .vdd_sample, .impedance_raw, .impedance_offset,
        .drive_en, .current_loop_en, .tracking_update_en, .drive_amplitude,
        .current_limit_ma_x8, .polarity_status, .vdd_hi, .vdd_lo, .impedance_readback,
        .impedance_lsb_half, .frame_index, .short_fault, .motion_fault, .fault_irq,
        .uv_threshold_mv, .analog_filter_trim);
    hdao_act_model act (.sys_clk, .drive_en, .stuck, .short_cmd, .half_period_start,
        .frame_done, .motion_level, .short_pin);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wait_drive(input logic want);
        int i;
        i = 0;
        while (drive_en !== want && i < 300) begin
            @(negedge sys_clk);
            i++;
        end
        if (i == 300) begin
            chk(drive_en, want);
            complete_run();
        end
    endtask
    // requests are one-cycle pulses: 0 play, 1 stop, 2 fault clear
    task automatic pulse(input int k);
        @(negedge sys_clk);
        play_req = (k == 0);
        stop_req = (k == 1);
        fault_clear = (k == 2);
        @(negedge sys_clk);
        play_req = 1'b0;
        stop_req = 1'b0;
        fault_clear = 1'b0;
    endtask
    task automatic t_reset;
        chk({drive_en, frame_index, short_fault, motion_fault, polarity_status}, 0);
        chk({vdd_hi, vdd_lo}, 0);
        chk(uv_threshold_mv, 12'haf0);
        $display("test reset done");
    endtask
    task automatic t_options;
        @(negedge sys_clk);
        for (int s = 0; s < 4; s++) begin
            undervoltage_threshold_sel = s[1:0];
            #1 chk(uv_threshold_mv, 2700 + 100 * s);
        end
        for (int d = 0; d < 2; d++) begin
            current_range_double = d[0];
            #1 chk(current_limit_ma_x8, d ? 6'h26 : 6'h13);
            chk(impedance_lsb_half, d);
        end
        current_range_double = 1'b0;
        impedance_offset_en = 1'b1;
        #1 chk(analog_filter_trim, 5'h0b);
        filter_cap_trim = 2'h0; // above 41 ohm
        filter_res_trim = 2'h3; // 46 ohm, 250 uH or more
        filter_low_bandwidth = 1'b1; // 2 mH
        #1 chk(analog_filter_trim, 5'h1c);
        @(negedge sys_clk);
        chk(impedance_readback, 10'h2c8);
        impedance_offset_en = 1'b0;
        // a held clock enable must swallow a play request
        clk_en = 1'b0;
        pulse(0);
        chk(drive_en, 0);
        clk_en = 1'b1;
        $display("test options done");
    endtask
    task automatic t_play(input logic pause, input logic [3:0] frames);
        int brake_n, i, maxf;
        logic pol;
        brake_n = 0;
        i = 0;
        maxf = 0;
        tracking_pause_on_brake = pause;
        sequence_frames = frames;
        vdd_sample = 14'h2a5b;
        pulse(0);
        wait_drive(1'b1);
        chk(current_loop_en, 1);
        pol = polarity_status;
        while (drive_en === 1'b1 && i < 300) begin
            if (tracking_update_en === 1'b0) brake_n++;
            if (frame_index > maxf) maxf = frame_index;
            // the pulse seen here stood at the last rising edge, taken while playing
            if (i > 0 && half_period_start === 1'b1) chk(polarity_status ^ pol, 1);
            pol = polarity_status;
            @(negedge sys_clk);
            i++;
        end
        chk(maxf, frames);
        chk(brake_n != 0, pause);
        chk({vdd_hi, vdd_lo}, 14'h2a5b);
        chk(impedance_readback, 10'h2c3);
        $display("test play done");
    endtask
    task automatic t_amp;
        logic [13:0] v [3] = '{14'h3fff, 14'h0800, 14'h3fff};
        logic [3:0] m [3] = '{4'h0, 4'h1, 4'h0};
        logic [11:0] e [3] = '{12'h800, 12'h100, 12'hfff};
        int j;
        logic pol;
        sequence_frames = 4'hf;
        for (int k = 0; k < 3; k++) begin
            vdd_sample = v[k];
            vdd_margin = m[k];
            direct_override_mode = (k < 2);
            pulse(0);
            wait_drive(1'b1);
            repeat (3) @(negedge sys_clk);
            chk(drive_amplitude, e[k]);
            if (k == 0) begin
                j = 0;
                pol = polarity_status;
                while (polarity_status === pol && j < 20) begin
                    @(negedge sys_clk);
                    j++;
                end
                chk(j < 20, 1);
                direct_amplitude_value = 12'h600;
                repeat (2) @(negedge sys_clk);
                chk(drive_amplitude, 12'h600);
            end
            pulse(1);
            wait_drive(1'b0);
        end
        $display("test amplitude done");
    endtask
    task automatic t_short(input logic sa);
        standalone_mode = sa;
        pulse(0);
        wait_drive(1'b1);
        short_cmd = 1'b1;
        wait_drive(1'b0);
        chk(current_loop_en, 0);
        short_cmd = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk({short_fault, fault_irq}, sa ? 2'h0 : 2'h3);
        if (!sa) begin
            pulse(0);
            repeat (3) @(negedge sys_clk);
            chk(drive_en, 0);
            pulse(2);
        end
        pulse(0);
        wait_drive(1'b1);
        pulse(1);
        wait_drive(1'b0);
        standalone_mode = 1'b0;
        $display("test short done");
    endtask
    task automatic t_motion;
        stuck = 1'b1;
        pulse(0);
        wait_drive(1'b1);
        wait_drive(1'b0);
        chk(motion_fault, 1);
        pulse(2);
        motion_fault_threshold = 8'h00; // coin actuator: motion check off
        pulse(0);
        wait_drive(1'b1);
        repeat (20) @(negedge sys_clk);
        chk({drive_en, motion_fault}, 2'h2);
        stuck = 1'b0;
        pulse(1);
        wait_drive(1'b0);
        $display("test motion done");
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_options();
        t_play(1'b1, 4'h2);
        t_play(1'b0, 4'h0);
        t_amp();
        t_short(1'b0);
        t_short(1'b1);
        t_motion();
        complete_run();
    end
endmodule // tb
